// [core/host_bus_pkg.sv]
// Shared constants and types for the host-bus emulation block
package host_bus_pkg;

  // ==========================================================
  // Command opcodes and response codes
  localparam logic [7:0] OP_BUS_READ = 8'h01;
  localparam logic [7:0] OP_BUS_WRITE = 8'h02;
  localparam logic [7:0] OP_AUX_SET = 8'h03;
  localparam logic [7:0] OP_AUX_GET = 8'h04;
  localparam logic [7:0] OP_WAIT_HIGH = 8'h05;
  localparam logic [7:0] OP_WAIT_LOW = 8'h06;
  localparam logic [7:0] RESP_BAD_OP = 8'hfa;

  // ==========================================================
  // Argument slots and widths
  localparam int NUM_ARGS = 3;
  localparam int ARG_ADDR_HI = 0;
  localparam int ARG_ADDR_LO = 1;
  localparam int ARG_WDATA = 2;
  localparam int ARG_AUX_VAL = 0;
  localparam int ARG_AUX_DIR = 1;
  localparam logic [1:0] NARGS_NONE = 2'h0;
  localparam logic [1:0] NARGS_AUX = 2'h2;
  localparam logic [1:0] NARGS_READ = 2'h2;
  localparam logic [1:0] NARGS_WRITE = 2'h3;
  localparam int NUM_AUX = 2;
  localparam logic [5:0] AUX_RESP_PAD = 6'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] AUX_ZERO = 2'h0;

  // ==========================================================
  // Timing: one bus phase lasts half a master clock period
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BUS_PHASE_NS = 20;
  localparam int BUS_PHASE_CYCLES = (BUS_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // State machines
  typedef enum {B_IDLE, B_ADDR, B_ALE, B_ALE_OFF, B_TURN, B_STROBE, B_HOLD} bus_state_t;
  typedef enum {C_OP, C_ARG, C_GO, C_BUSW, C_AUXSET, C_WAIT, C_RSP} cmd_state_t;

endpackage

// [core/master_clock_divider.sv]
// Divider that makes the bus master clock and the bus phase tick
`timescale 1ns/1ps
module master_clock_divider
  import host_bus_pkg::*;
#(
  parameter int HALF_CYCLES = BUS_PHASE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  output logic tick,
  output logic clk_out_q
);

  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] cnt_q;
  wire logic wrap = (cnt_q == CNT_LAST);

  assign tick = clk_en && wrap;

  // ==========================================================
  // Counter and clock toggle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= CNT_ZERO;
      clk_out_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= wrap ? CNT_ZERO : cnt_q + CNT_ONE;
      if (wrap)
        clk_out_q <= !clk_out_q;
    end
  end

  // ==========================================================
  // Checks
  a_clock_toggles: assert property (@(posedge clock) disable iff (!rst_b)
    tick |=> (clk_out_q != $past(clk_out_q)))
    else $error("master clock did not toggle on tick");

endmodule

// [core/aux_io_port.sv]
// Two software-controlled auxiliary pins
`timescale 1ns/1ps
module aux_io_port
  import host_bus_pkg::*;
#(
  parameter int WIDTH = NUM_AUX
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic set_stb,
  input wire logic [WIDTH-1:0] set_value,
  input wire logic [WIDTH-1:0] set_dir,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  // ==========================================================
  // Per-pin output level and direction
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
        begin
          pin_out[i] <= 1'b0;
          pin_oe[i] <= 1'b0;
        end
        else if (clk_en && set_stb)
        begin
          pin_out[i] <= set_value[i];
          pin_oe[i] <= set_dir[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  a_aux_set_lands: assert property (@(posedge clock) disable iff (!rst_b)
    (clk_en && set_stb) |=> (pin_out == $past(set_value) && pin_oe == $past(set_dir)))
    else $error("aux pin set did not take effect");

endmodule

// [core/host_bus_emulator.sv]
// Command-driven 8-bit multiplexed host bus master with auxiliary pins
`timescale 1ns/1ps
module host_bus_emulator
  import host_bus_pkg::*;
#(
  parameter int PHASE_CYCLES = BUS_PHASE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic mode_en,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  input wire logic [7:0] mux_addr_data_bus_in,
  output logic [7:0] mux_addr_data_bus_out,
  output logic mux_addr_data_bus_oe,
  output logic [7:0] addr_high_out,
  output logic chip_select_b,
  output logic addr_latch,
  output logic read_strobe_b,
  output logic write_strobe_b,
  input wire logic cycle_wait_in,
  output logic bus_master_clock,
  input wire logic aux_pin_zero_in,
  output logic aux_pin_zero_out,
  output logic aux_pin_zero_oe,
  input wire logic aux_irq_wait_pin_in,
  output logic aux_irq_wait_pin_out,
  output logic aux_irq_wait_pin_oe
);

  // ==========================================================
  // Opcode decoding
  function automatic logic [1:0] arg_count(input logic [7:0] op);
    unique case (op)
      OP_BUS_READ: arg_count = NARGS_READ;
      OP_BUS_WRITE: arg_count = NARGS_WRITE;
      OP_AUX_SET: arg_count = NARGS_AUX;
      default: arg_count = NARGS_NONE;
    endcase
  endfunction

  function automatic cmd_state_t exec_state(input logic [7:0] op);
    unique case (op)
      OP_BUS_READ, OP_BUS_WRITE: exec_state = C_GO;
      OP_AUX_SET: exec_state = C_AUXSET;
      OP_WAIT_HIGH, OP_WAIT_LOW: exec_state = C_WAIT;
      default: exec_state = C_RSP;
    endcase
  endfunction

  // ==========================================================
  // State
  cmd_state_t cmd_q, cmd_d;
  bus_state_t bus_q, bus_d;
  logic [7:0] op_q, op_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] args_q [NUM_ARGS];
  logic is_write_q;
  logic [7:0] rdata_q;
  logic [7:0] rsp_data_d;
  logic tick;
  logic [1:0] aux_out, aux_oe;

  // ==========================================================
  // Named decode wires
  wire logic take = cmd_valid && cmd_ready && clk_en;
  wire logic last_arg = (idx_q == arg_count(op_q) - 2'h1);
  wire logic bus_start = (cmd_q == C_GO);
  wire logic bus_done = (bus_q == B_HOLD) && tick;
  wire logic wait_level = (op_q == OP_WAIT_HIGH);
  // Aux pin one is read as an input here; driving it would defeat the wait
  wire logic wait_met = (aux_irq_wait_pin_in == wait_level);
  wire logic [7:0] op_sel = (cmd_q == C_OP) ? cmd_data : op_q;
  wire logic [7:0] aux_levels = {AUX_RESP_PAD, aux_irq_wait_pin_in, aux_pin_zero_in};
  wire logic enter_rsp = (cmd_d == C_RSP) && (cmd_q != C_RSP);
  wire logic accept_d = mode_en && ((cmd_d == C_OP) || (cmd_d == C_ARG));
  wire logic addr_phase_d = (bus_d == B_ADDR) || (bus_d == B_ALE) || (bus_d == B_ALE_OFF);
  wire logic data_phase_d = (bus_d == B_TURN) || (bus_d == B_STROBE) || (bus_d == B_HOLD);
  wire logic write_d = bus_start ? (op_q == OP_BUS_WRITE) : is_write_q;
  wire logic read_capture = (bus_q == B_STROBE) && (bus_d == B_HOLD) && !is_write_q;

  assign rsp_data_d = (cmd_q == C_BUSW) ? rdata_q :
                      (op_sel == OP_AUX_GET) ? aux_levels : RESP_BAD_OP;

  // ==========================================================
  // Command engine
  always_comb
  begin
    cmd_d = cmd_q;
    op_d = op_q;
    idx_d = idx_q;
    unique case (cmd_q)
      C_OP:
        if (take)
        begin
          op_d = cmd_data;
          idx_d = 2'h0;
          cmd_d = (arg_count(cmd_data) == NARGS_NONE) ? exec_state(cmd_data) : C_ARG;
        end
      C_ARG:
        if (take)
        begin
          idx_d = idx_q + 2'h1;
          if (last_arg)
            cmd_d = exec_state(op_q);
        end
      C_GO: cmd_d = C_BUSW;
      C_BUSW:
        if (bus_done)
          cmd_d = is_write_q ? C_OP : C_RSP;
      C_AUXSET: cmd_d = C_OP;
      C_WAIT:
        if (wait_met)
          cmd_d = C_OP;
      C_RSP:
        if (rsp_ready)
          cmd_d = C_OP;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_q <= C_OP;
      op_q <= BYTE_ZERO;
      idx_q <= 2'h0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= BYTE_ZERO;
    end
    else if (clk_en)
    begin
      cmd_q <= cmd_d;
      op_q <= op_d;
      idx_q <= idx_d;
      cmd_ready <= accept_d;
      rsp_valid <= (cmd_d == C_RSP);
      if (enter_rsp)
        rsp_data <= rsp_data_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ARGS; gi++)
    begin : g_arg
      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          args_q[gi] <= BYTE_ZERO;
        else if (take && cmd_q == C_ARG && idx_q == 2'(gi))
          args_q[gi] <= cmd_data;
      end
    end
  endgenerate

  // ==========================================================
  // Bus cycle sequencer, one phase per master clock half period
  always_comb
  begin
    bus_d = bus_q;
    unique case (bus_q)
      B_IDLE:
        if (bus_start)
          bus_d = B_ADDR;
      B_ADDR:
        if (tick)
          bus_d = B_ALE;
      B_ALE:
        if (tick)
          bus_d = B_ALE_OFF;
      B_ALE_OFF:
        if (tick)
          bus_d = B_TURN;
      B_TURN:
        if (tick)
          bus_d = B_STROBE;
      B_STROBE:
        if (tick && cycle_wait_in)
          bus_d = B_HOLD;
      B_HOLD:
        if (tick)
          bus_d = B_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_q <= B_IDLE;
      is_write_q <= 1'b0;
      rdata_q <= BYTE_ZERO;
      chip_select_b <= 1'b1;
      addr_latch <= 1'b0;
      read_strobe_b <= 1'b1;
      write_strobe_b <= 1'b1;
      mux_addr_data_bus_oe <= 1'b0;
      mux_addr_data_bus_out <= BYTE_ZERO;
      addr_high_out <= BYTE_ZERO;
    end
    else if (clk_en)
    begin
      bus_q <= bus_d;
      is_write_q <= write_d;
      chip_select_b <= (bus_d == B_IDLE);
      addr_latch <= (bus_d == B_ALE);
      read_strobe_b <= !((bus_d == B_STROBE) && !write_d);
      write_strobe_b <= !((bus_d == B_STROBE) && write_d);
      // Shared byte: address, then write data or released for a read
      mux_addr_data_bus_oe <= addr_phase_d || (data_phase_d && write_d);
      if (bus_start)
      begin
        mux_addr_data_bus_out <= args_q[ARG_ADDR_LO];
        addr_high_out <= args_q[ARG_ADDR_HI];
      end
      else if (bus_q == B_ALE_OFF && bus_d == B_TURN)
        mux_addr_data_bus_out <= write_d ? args_q[ARG_WDATA] : BYTE_ZERO;
      if (read_capture)
        rdata_q <= mux_addr_data_bus_in;
    end
  end

  // ==========================================================
  // Master clock and auxiliary pins
  master_clock_divider #(.HALF_CYCLES(PHASE_CYCLES)) u_div (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .tick(tick),
    .clk_out_q(bus_master_clock)
  );

  aux_io_port #(.WIDTH(NUM_AUX)) u_aux (
    .clock(clock),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .set_stb(cmd_q == C_AUXSET),
    .set_value(args_q[ARG_AUX_VAL][1:0]),
    .set_dir(args_q[ARG_AUX_DIR][1:0]),
    .pin_out(aux_out),
    .pin_oe(aux_oe)
  );

  assign aux_pin_zero_out = aux_out[0];
  assign aux_pin_zero_oe = aux_oe[0];
  assign aux_irq_wait_pin_out = aux_out[1];
  assign aux_irq_wait_pin_oe = aux_oe[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_read_done;
    bus_done && !is_write_q && clk_en;
  endsequence

  // Latch phase lasts a whole bus phase; the address must outlive it
  sequence s_latch_then_release;
    !addr_latch && mux_addr_data_bus_oe && read_strobe_b && write_strobe_b
      && $stable(mux_addr_data_bus_out);
  endsequence

  a_cs_covers_strobe: assert property (
    (!read_strobe_b || !write_strobe_b) |-> !chip_select_b)
    else $error("strobe active without chip select");

  a_ale_with_addr: assert property (
    $rose(addr_latch) |-> (!chip_select_b && mux_addr_data_bus_oe && read_strobe_b))
    else $error("address latch without address on bus");

  a_read_bus_free: assert property (
    !read_strobe_b |-> (!mux_addr_data_bus_oe && !addr_latch))
    else $error("bus driven during read strobe");

  a_write_setup: assert property (
    $fell(write_strobe_b) |-> ($past(mux_addr_data_bus_oe) && mux_addr_data_bus_oe
      && $stable(mux_addr_data_bus_out)))
    else $error("write data not set up before strobe");

  a_write_hold: assert property (
    $rose(write_strobe_b) |-> (mux_addr_data_bus_oe && $stable(mux_addr_data_bus_out)))
    else $error("write data not held after strobe");

  a_wait_stretch: assert property (
    (!read_strobe_b && !cycle_wait_in) |=> !read_strobe_b)
    else $error("read cycle ended while ready low");

  a_addr_high_held: assert property (
    (!chip_select_b && $past(!chip_select_b)) |-> $stable(addr_high_out))
    else $error("upper address changed inside cycle");

  a_pin_wait_stall: assert property (
    (cmd_q == C_WAIT && !wait_met) |=> (cmd_q == C_WAIT && !cmd_ready))
    else $error("wait command did not stall");

  a_read_answer: assert property (
    s_read_done |=> (rsp_valid && rsp_data == $past(rdata_q)))
    else $error("read result not returned");

  a_latch_order: assert property (
    $fell(addr_latch) |-> s_latch_then_release)
    else $error("address not held after latch pulse");

  a_mode_gate: assert property (
    ($past(!mode_en) && $past(clk_en)) |-> !cmd_ready)
    else $error("command taken outside emulation mode");

  a_rsp_holds: assert property (
    (rsp_valid && !rsp_ready) |=> (rsp_valid && $stable(rsp_data)))
    else $error("response dropped before it was taken");

endmodule

// [tb/periph_model.sv]
// Behavioural peripheral chip on the multiplexed 8-bit bus
`timescale 1ns/1ps
module periph_model
(
  input wire logic clock,
  input wire logic [7:0] ad,
  input wire logic [7:0] a_high,
  input wire logic cs_b,
  input wire logic latch,
  input wire logic rd_b,
  input wire logic wr_b,
  input wire logic [3:0] stall,
  output logic [7:0] ad_drv,
  output logic ready
);
  logic [7:0] mem [0:255];
  logic [7:0] key_q = 8'h00;
  logic [7:0] idle_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic strobe_q = 1'b0;
  logic wr_q = 1'b1;
  wire strobe = !cs_b && (!rd_b || !wr_b);

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = i[7:0] ^ 8'h3c;
  end

  // ==========================================================
  // Address capture, write capture and wait stretching
  always @(posedge clock)
  begin
    idle_q <= ~idle_q;
    strobe_q <= strobe;
    wr_q <= wr_b;
    if (latch && !cs_b)
      key_q <= a_high ^ ad;
    if (!wr_q && wr_b && !cs_b)
      mem[key_q] <= ad;
    if (strobe && !strobe_q)
      cnt_q <= stall;
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end

  // Ready drops at once on a new strobe so it cannot be missed
  assign ready = (cnt_q == 4'h0) && !(strobe && !strobe_q);
  // Released bus shows a pattern that changes every cycle
  assign ad_drv = (!cs_b && !rd_b) ? mem[key_q] : idle_q;
endmodule

// [tb/host_bus_emulator_bench.sv]
// Random and corner-case bench for the host-bus emulator
`timescale 1ns/1ps
module host_bus_emulator_bench;
  import host_bus_pkg::*;
  localparam int PH = 2;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic mode_en = 1'b1;
  logic cmd_valid = 1'b0;
  logic rsp_rdy = 1'b0;
  logic run = 1'b1;
  logic [7:0] cmd_data = 8'h00;
  logic p0_ext = 1'b0;
  logic p1_ext = 1'b0;
  logic [3:0] stall = 4'h0;
  logic cmd_ready, rsp_valid, ad_oe, cs_b, ale, rd_b, wr_b, ready, mclk;
  logic p0_out, p0_oe, p1_out, p1_oe, lvl, busy, m, last_wr;
  logic [7:0] rsp_data, ad_out, ad_in, a_high, m_drv, d;
  logic [7:0] exp_ahi, exp_alo, exp_wd;
  logic [7:0] shadow [0:255];
  logic [15:0] a;
  logic [1:0] v, dir;
  int miscompares = 0;
  int n_tests = 0;
  int slen = 0;
  int n;

  always #2 clock = ~clock;
  assign ad_in = ad_oe ? ad_out : m_drv;

  host_bus_emulator #(.PHASE_CYCLES(PH)) i_dut (
    .clock(clock), .rst_b(rst_b), .clk_en(run), .mode_en(mode_en),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_rdy),
    .mux_addr_data_bus_in(ad_in), .mux_addr_data_bus_out(ad_out),
    .mux_addr_data_bus_oe(ad_oe), .addr_high_out(a_high), .chip_select_b(cs_b),
    .addr_latch(ale), .read_strobe_b(rd_b), .write_strobe_b(wr_b),
    .cycle_wait_in(ready), .bus_master_clock(mclk),
    .aux_pin_zero_in(p0_oe ? p0_out : p0_ext), .aux_pin_zero_out(p0_out),
    .aux_pin_zero_oe(p0_oe), .aux_irq_wait_pin_in(p1_oe ? p1_out : p1_ext),
    .aux_irq_wait_pin_out(p1_out), .aux_irq_wait_pin_oe(p1_oe));

  periph_model i_periph (.clock(clock), .ad(ad_in), .a_high(a_high), .cs_b(cs_b),
    .latch(ale), .rd_b(rd_b), .wr_b(wr_b), .stall(stall), .ad_drv(m_drv), .ready(ready));

  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Command and response drivers
  task automatic send(input int nb, input logic [7:0] b0, input logic [7:0] b1 = 8'h00,
                      input logic [7:0] b2 = 8'h00, input logic [7:0] b3 = 8'h00);
    logic [7:0] b [4];
    int k;
    b = '{b0, b1, b2, b3};
    for (int i = 0; i < nb; i++)
    begin
      cmd_valid = 1'b1;
      cmd_data = b[i];
      k = 0;
      do
      begin
        @(posedge clock);
        k++;
      end while (cmd_ready !== 1'b1 && k < 500);
      if (cmd_ready !== 1'b1)
        miscompares++;
      #1;
    end
    cmd_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Response is held back until the bench asks for it
  task automatic get(output logic [7:0] r);
    int k;
    k = 0;
    rsp_rdy = 1'b1;
    do
    begin
      @(posedge clock);
      k++;
    end while (rsp_valid !== 1'b1 && k < 500);
    r = rsp_data;
    if (rsp_valid !== 1'b1)
      miscompares++;
    #1;
    rsp_rdy = 1'b0;
  endtask

  // One bus transfer; waits until the engine is free again
  task automatic bus(input logic wr, input logic [15:0] ad16, input logic [7:0] dat);
    int k;
    exp_ahi = ad16[15:8];
    exp_alo = ad16[7:0];
    exp_wd = dat;
    stall = 4'($urandom % 7);
    if (wr)
    begin
      send(4, OP_BUS_WRITE, ad16[15:8], ad16[7:0], dat);
      shadow[ad16[15:8] ^ ad16[7:0]] = dat;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 500)
      begin
        @(posedge clock);
        k++;
      end
      if (cmd_ready !== 1'b1)
        miscompares++;
      #1;
    end
    else
    begin
      send(3, OP_BUS_READ, ad16[15:8], ad16[7:0]);
      get(d);
      check("read_data", d, shadow[ad16[15:8] ^ ad16[7:0]]);
    end
  endtask

  // ==========================================================
  // Bus monitor
  always @(posedge clock)
  begin
    if (rst_b && ale === 1'b1)
    begin
      check("latch_addr", {ad_oe, ad_out}, {1'b1, exp_alo});
      check("high_addr", a_high, exp_ahi);
    end
    if (rst_b && (rd_b === 1'b0 || wr_b === 1'b0))
    begin
      slen++;
      last_wr = !wr_b;
      check("strobe_frame", {cs_b, ale}, 2'b00);
      check("strobe_oe", ad_oe, !wr_b);
      if (wr_b === 1'b0)
        check("wr_data", ad_out, exp_wd);
    end
    else if (slen != 0)
    begin
      check("stretch", slen >= stall, 1'b1);
      if (last_wr)
        check("wr_hold", {ad_oe, ad_out}, {1'b1, exp_wd});
      slen = 0;
    end
  end

  // Watchdog, far beyond the few thousand cycles the tests need
  initial
  begin
    #100000;
    miscompares++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(1));
    for (int i = 0; i < 256; i++)
      shadow[i] = i[7:0] ^ 8'h3c;
    repeat (12) @(posedge clock);
    check("reset_idle", {cs_b, rd_b, wr_b, ale, ad_oe, cmd_ready}, 6'b111000);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      a = (i < 2) ? {16{i[0]}} : 16'($urandom);
      bus(1'b1, a, 8'($urandom));
      bus(1'b0, a, 8'h00);
      bus(1'b0, 16'($urandom), 8'h00);
    end
    for (int i = 0; i < 16; i++)
    begin
      v = 2'(i);
      dir = 2'(i >> 2);
      {p1_ext, p0_ext} = 2'($urandom);
      send(3, OP_AUX_SET, {6'h00, v}, {6'h00, dir});
      repeat (3) @(posedge clock);
      check("aux_pins", {p1_oe, p0_oe, p1_out & p1_oe, p0_out & p0_oe}, {dir, v & dir});
      #1;
      send(1, OP_AUX_GET);
      get(d);
      check("aux_get", d, {6'h00, (v & dir) | ({p1_ext, p0_ext} & ~dir)});
    end
    foreach (shadow[i])
      if (i == 0 || i == 7 || i == 255)
      begin
        send(1, 8'(i));
        get(d);
        check("bad_op", d, RESP_BAD_OP);
      end
    send(3, OP_AUX_SET, 8'h00, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      lvl = (i == 0);
      p1_ext = !lvl;
      send(1, lvl ? OP_WAIT_HIGH : OP_WAIT_LOW);
      cmd_valid = 1'b1;
      cmd_data = OP_BUS_READ;
      busy = 1'b0;
      repeat (30)
      begin
        @(posedge clock);
        busy = busy | !cs_b | cmd_ready;
      end
      check("wait_stall", busy, 1'b0);
      #1;
      p1_ext = lvl;
      bus(1'b0, 16'($urandom), 8'h00);
    end
    mode_en = 1'b0;
    @(posedge clock);
    #1;
    cmd_valid = 1'b1;
    cmd_data = OP_AUX_GET;
    repeat (10) @(posedge clock);
    check("mode_off", {cmd_ready, rsp_valid}, 2'b00);
    #1;
    mode_en = 1'b1;
    send(1, OP_AUX_GET);
    get(d);
    check("mode_on", d, {6'h00, p1_ext, p0_ext});
    // First pass with the clock enable low: the master clock must freeze
    for (int f = 0; f < 2; f++)
    begin
      run = f[0];
      @(posedge clock);
      m = mclk;
      n = 0;
      repeat (40)
      begin
        @(posedge clock);
        n += int'(mclk !== m);
        m = mclk;
      end
      check("master_clock", 16'(n), 16'(f * 40 / PH));
      #1;
    end
    test_done();
  end
endmodule
